// ===== hdl/pbc_pkg.sv
// package of constants, types and decode helpers for the port pin bit configuration block
//
// Notes on behaviour
// - an input pin has its output driver fully off, leaving the pin floating.
// - in input mode the pin level is latched at each instruction start.
// - in input mode master still moves to slave at each instruction end.
// - low control bits 00 bidirectional, 10 output, 01 input, 11 peripheral output.
// - input mode uses cmos levels when upper bit is 0; other modes use ttl.
// - output mode drives push-pull when upper bit is 0, open-drain when 1.
// - output mode copies master into input and slave latches at instruction end.
// - bidirectional mode is open-drain, with weak pull-up when upper bit is 0.
// - bidirectional mode samples pin at start, moves master to slave at end.
// - peripheral output mode lets the peripheral load the slave latch.
// - peripheral output with nothing attached: push-pull high, open-drain released.
// - each pin's input buffer feeds every peripheral input on that pin.
// - port reads and writes keep working while peripherals use the pin.
// - converter pin in open-drain ttl peripheral mode forces peripheral output high.
// - converter pin with all three bits set is analog input, driver off.
// - data writes load the master latch always; reads return the input latch.
// - reset gives bidirectional weak pull-up mode and data register all ones.
// - several peripheral outputs on one pin are combined by logical and.
package pbc_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int PBC_PINS     = 8;
  localparam int PBC_AF_SRCS  = 2;
  localparam int PBC_SEL_W    = 2;

  // ****************************************
  // register selects
  // ****************************************
  localparam logic [1:0] PBC_SEL_DATA  = 2'h0;
  localparam logic [1:0] PBC_SEL_LOWER = 2'h1;
  localparam logic [1:0] PBC_SEL_MID   = 2'h2;
  localparam logic [1:0] PBC_SEL_UPPER = 2'h3;

  // ****************************************
  // reset values and pin capabilities
  // ****************************************
  localparam logic [7:0] PBC_DATA_RST  = 8'hff;
  localparam logic [7:0] PBC_CTRL_RST  = 8'h00;
  localparam logic [7:0] PBC_ADC_PINS  = 8'h0f;
  localparam logic [7:0] PBC_SCHM_PINS = 8'h00;
  localparam logic [7:0] PBC_WPU_PINS  = 8'hff;

  // ****************************************
  // pin modes
  // ****************************************
  typedef enum logic [4:0] {
    PBC_MODE_BID    = 5'h01,
    PBC_MODE_OUT    = 5'h02,
    PBC_MODE_IN     = 5'h04,
    PBC_MODE_AFOUT  = 5'h08,
    PBC_MODE_ANALOG = 5'h10
  } pbc_mode_t;

  typedef struct packed {
    logic upper;
    logic middle;
    logic lower;
  } pbc_cfg_t;

  typedef struct packed {
    logic drv_val;
    logic drv_oe_n;
    logic pullup_en;
    logic ttl_sel;
    logic analog_en;
  } pbc_drive_t;

  typedef struct packed {
    logic [PBC_SEL_W-1:0] sel;
    logic                 wr_en;
    logic                 rd_en;
    logic [7:0]           wdata;
  } pbc_reg_req_t;

  // control bits of one pin to its mode
  function automatic pbc_mode_t pbc_decode(input pbc_cfg_t cfg, input logic is_adc);
    pbc_mode_t m;
    m = PBC_MODE_BID;
    unique case ({cfg.middle, cfg.lower})
      2'b00: m = PBC_MODE_BID;
      2'b10: m = PBC_MODE_OUT;
      2'b01: m = PBC_MODE_IN;
      2'b11: m = (is_adc && cfg.upper) ? PBC_MODE_ANALOG : PBC_MODE_AFOUT;
    endcase
    return m;
  endfunction : pbc_decode

endpackage : pbc_pkg

// ===== hdl/pbc_sync.sv
// two-stage synchroniser for the pin inputs
`timescale 1ns/1ps
module pbc_sync (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // data
  input  wire logic [7:0] async_in,
  output logic      [7:0] sync_out
);
  import pbc_pkg::*;

  logic [7:0] meta_r;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      meta_r   <= 8'h00;
      sync_out <= 8'h00;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : pbc_sync

// ===== hdl/pbc_pin_cell.sv
// output buffer and input threshold selection for one pin
`timescale 1ns/1ps
module pbc_pin_cell (
  // configuration
  input  wire pbc_pkg::pbc_cfg_t   cfg,
  input  wire logic                is_adc,
  input  wire logic                is_schmitt,
  input  wire logic                has_wpu,
  // latch
  input  wire logic                slave,
  // buffer controls
  output pbc_pkg::pbc_drive_t      drive
);
  import pbc_pkg::*;

  pbc_mode_t mode;

  always_comb begin
    mode            = pbc_decode(cfg, is_adc);
    drive.drv_val   = slave;
    drive.drv_oe_n  = 1'b1;
    drive.pullup_en = 1'b0;
    drive.analog_en = 1'b0;
    drive.ttl_sel   = !is_schmitt;
    unique case (mode)
      PBC_MODE_IN: begin
        drive.drv_oe_n = 1'b1;
        drive.ttl_sel  = !is_schmitt && cfg.upper;
      end
      PBC_MODE_OUT, PBC_MODE_AFOUT: begin
        // open-drain only pulls low; push-pull drives both levels
        drive.drv_oe_n = cfg.upper ? slave : 1'b0;
      end
      PBC_MODE_BID: begin
        drive.drv_oe_n  = slave;
        drive.pullup_en = !cfg.upper && has_wpu;
      end
      PBC_MODE_ANALOG: begin
        // released high on the same edge as the analog enable
        drive.drv_val   = 1'b1;
        drive.drv_oe_n  = 1'b1;
        drive.analog_en = 1'b1;
      end
    endcase
  end

endmodule : pbc_pin_cell

// ===== hdl/pbc_port.sv
// eight-bit configurable port: registers, latches, peripheral routing and pin drive
`timescale 1ns/1ps
module pbc_port (
  // clock and reset
  input  wire logic                                    clock,
  input  wire logic                                    resetn,
  // instruction timing from the core
  input  wire logic                                    instr_start,
  input  wire logic                                    instr_end,
  // register access from the core
  input  wire pbc_pkg::pbc_reg_req_t                   reg_req,
  output logic [7:0]                                   reg_rdata,
  // pins
  input  wire logic [7:0]                              pin_in,
  output logic [7:0]                                   pin_out,
  output logic [7:0]                                   pin_oe_n,
  output logic [7:0]                                   pin_pullup_en,
  output logic [7:0]                                   pin_ttl_sel,
  output logic [7:0]                                   pin_analog_en,
  // peripherals
  input  wire logic [pbc_pkg::PBC_PINS*pbc_pkg::PBC_AF_SRCS-1:0] periph_out,
  input  wire logic [pbc_pkg::PBC_PINS*pbc_pkg::PBC_AF_SRCS-1:0] periph_attached,
  output logic [7:0]                                   periph_in
);
  import pbc_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic [7:0]  port_data_register_r;   // master latches
  logic [7:0]  slave_r;
  logic [7:0]  in_latch_r;
  logic [7:0]  cfg_upper_r;
  logic [7:0]  cfg_middle_r;
  logic [7:0]  cfg_lower_r;
  logic [7:0]  pin_sync;
  logic [7:0]  af_val;
  pbc_cfg_t    cfg       [PBC_PINS];
  pbc_mode_t   mode      [PBC_PINS];
  pbc_drive_t  drive     [PBC_PINS];
  logic [7:0]  slave_nxt;
  logic [7:0]  in_latch_nxt;
  logic [7:0]  rdata_nxt;

  // ****************************************
  // pin input synchroniser
  // ****************************************
  pbc_sync u_sync (
    .clock    (clock),
    .resetn   (resetn),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // ****************************************
  // per-pin decode and buffer cell
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < PBC_PINS; gi++) begin : g_pin
      assign cfg[gi].upper  = cfg_upper_r[gi];
      assign cfg[gi].middle = cfg_middle_r[gi];
      assign cfg[gi].lower  = cfg_lower_r[gi];
      assign mode[gi]       = pbc_decode(cfg[gi], PBC_ADC_PINS[gi]);

      pbc_pin_cell u_cell (
        .cfg        (cfg[gi]),
        .is_adc     (PBC_ADC_PINS[gi]),
        .is_schmitt (PBC_SCHM_PINS[gi]),
        .has_wpu    (PBC_WPU_PINS[gi]),
        .slave      (slave_r[gi]),
        .drive      (drive[gi])
      );
    end
  endgenerate

  // ****************************************
  // peripheral output combining
  // ****************************************
  // unattached sources count as ones, so no source drives the pin high in push-pull and releases it in open-drain
  always_comb begin
    af_val = 8'hff;
    for (int p = 0; p < PBC_PINS; p++) begin
      for (int s = 0; s < PBC_AF_SRCS; s++) begin
        if (periph_attached[p*PBC_AF_SRCS+s]) begin
          af_val[p] = af_val[p] & periph_out[p*PBC_AF_SRCS+s];
        end
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cfg_upper_r  <= PBC_CTRL_RST;
      cfg_middle_r <= PBC_CTRL_RST;
      cfg_lower_r  <= PBC_CTRL_RST;
    end else if (reg_req.wr_en) begin
      unique case (reg_req.sel)
        PBC_SEL_UPPER: cfg_upper_r  <= reg_req.wdata;
        PBC_SEL_MID:   cfg_middle_r <= reg_req.wdata;
        PBC_SEL_LOWER: cfg_lower_r  <= reg_req.wdata;
        PBC_SEL_DATA:  ;
      endcase
    end
  end

  // ****************************************
  // master latches
  // ****************************************
  // written whatever the pin configuration
  always_ff @(posedge clock) begin
    if (!resetn) begin
      port_data_register_r <= PBC_DATA_RST;
    end else if (reg_req.wr_en && reg_req.sel == PBC_SEL_DATA) begin
      port_data_register_r <= reg_req.wdata;
    end
  end

  // ****************************************
  // slave latch next value
  // ****************************************
  always_comb begin
    slave_nxt = slave_r;
    for (int p = 0; p < PBC_PINS; p++) begin
      unique case (mode[p])
        PBC_MODE_AFOUT: begin
          // converter pin in open-drain ttl setting is held high
          if (PBC_ADC_PINS[p] && cfg[p].upper) begin
            slave_nxt[p] = 1'b1;
          end else begin
            slave_nxt[p] = af_val[p];
          end
        end
        PBC_MODE_ANALOG: begin
          slave_nxt[p] = 1'b1;
        end
        PBC_MODE_IN, PBC_MODE_OUT, PBC_MODE_BID: begin
          if (instr_end) begin
            slave_nxt[p] = port_data_register_r[p];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      slave_r <= PBC_DATA_RST;
    end else begin
      slave_r <= slave_nxt;
    end
  end

  // ****************************************
  // input latch next value
  // ****************************************
  always_comb begin
    in_latch_nxt = in_latch_r;
    for (int p = 0; p < PBC_PINS; p++) begin
      unique case (mode[p])
        PBC_MODE_OUT: begin
          if (instr_end) begin
            in_latch_nxt[p] = port_data_register_r[p];
          end
        end
        PBC_MODE_IN, PBC_MODE_BID, PBC_MODE_AFOUT, PBC_MODE_ANALOG: begin
          if (instr_start) begin
            in_latch_nxt[p] = pin_sync[p];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      in_latch_r <= PBC_DATA_RST;
    end else begin
      in_latch_r <= in_latch_nxt;
    end
  end

  // ****************************************
  // register read data
  // ****************************************
  always_comb begin
    rdata_nxt = reg_rdata;
    if (reg_req.rd_en) begin
      unique case (reg_req.sel)
        PBC_SEL_DATA:  rdata_nxt = in_latch_r;
        PBC_SEL_LOWER: rdata_nxt = cfg_lower_r;
        PBC_SEL_MID:   rdata_nxt = cfg_middle_r;
        PBC_SEL_UPPER: rdata_nxt = cfg_upper_r;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ****************************************
  // pin drive registers
  // ****************************************
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pin_out       <= PBC_DATA_RST;
      pin_oe_n      <= 8'hff;
      pin_pullup_en <= PBC_WPU_PINS;
      pin_ttl_sel   <= ~PBC_SCHM_PINS;
      pin_analog_en <= 8'h00;
    end else begin
      for (int p = 0; p < PBC_PINS; p++) begin
        pin_out[p]       <= drive[p].drv_val;
        pin_oe_n[p]      <= drive[p].drv_oe_n;
        pin_pullup_en[p] <= drive[p].pullup_en;
        pin_ttl_sel[p]   <= drive[p].ttl_sel;
        pin_analog_en[p] <= drive[p].analog_en;
      end
    end
  end

  // ****************************************
  // peripheral inputs
  // ****************************************
  // every peripheral sharing a pin sees its buffered level in any mode
  always_ff @(posedge clock) begin
    if (!resetn) begin
      periph_in <= 8'h00;
    end else begin
      periph_in <= pin_sync;
    end
  end

endmodule : pbc_port

// ===== test/pbc_pins_model.sv
// model of the external pin circuit: driver, outside forcing, pull-up or float
`timescale 1ns/1ps
module pbc_pins_model (
  // clock
  input  wire logic       clock,
  // device drive
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] pin_pullup_en,
  // outside forcing
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  // wire level
  output logic      [7:0] pin_in
);
  logic [7:0] float_r = 8'h5a;

  // ****************************************
  // pin level
  // ****************************************
  // floating pins wander every cycle
  always @(posedge clock) float_r <= ~float_r;
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
                | (pin_oe_n & ~ext_en & (pin_pullup_en | float_r));
endmodule : pbc_pins_model

// ===== test/pbc_port_asserts.sv
// concurrent checks on the port pin drive and register outputs
`timescale 1ns/1ps
module pbc_port_asserts (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  resetn,
  // core side
  input  wire pbc_pkg::pbc_reg_req_t reg_req,
  input  wire logic [7:0]            reg_rdata,
  // pins and peripherals
  input  wire logic [7:0]            pin_in,
  input  wire logic [7:0]            pin_out,
  input  wire logic [7:0]            pin_oe_n,
  input  wire logic [7:0]            pin_pullup_en,
  input  wire logic [7:0]            pin_ttl_sel,
  input  wire logic [7:0]            pin_analog_en,
  input  wire logic [7:0]            periph_in
);
  import pbc_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // ****************************************
  // sequences
  // ****************************************
  sequence s_run3;
    resetn [*3];
  endsequence
  sequence s_rst_state;
    pin_out == 8'hff && pin_oe_n == 8'hff && pin_pullup_en == 8'hff && pin_analog_en == 8'h00;
  endsequence

  // ****************************************
  // assertions
  // ****************************************
  a_reset_drive_state: assert property (disable iff (1'b0) !resetn |=> s_rst_state)
    else $error("drive state wrong after reset");
  a_analog_drv_off: assert property ((pin_analog_en & ~(pin_oe_n & pin_out)) == 8'h00)
    else $error("analog pin not released high");
  a_analog_pins_only: assert property ((pin_analog_en & ~PBC_ADC_PINS) == 8'h00)
    else $error("analog on a non converter pin");
  a_pullup_no_drive: assert property ((pin_pullup_en & ~pin_oe_n & pin_out) == 8'h00)
    else $error("pull-up pin driven high");
  a_pullup_no_analog: assert property ((pin_pullup_en & pin_analog_en) == 8'h00)
    else $error("pull-up on analog pin");
  a_input_drv_off: assert property ((~pin_ttl_sel & ~pin_oe_n) == 8'h00)
    else $error("input pin driver on");
  a_input_ttl_analog: assert property ((~pin_ttl_sel & (pin_pullup_en | pin_analog_en)) == 8'h00)
    else $error("cmos level outside input mode");
  a_periph_in_delay: assert property (s_run3 |=> periph_in == $past(pin_in, 3))
    else $error("peripheral input not three edges behind pin");
  a_rdata_hold: assert property (!reg_req.rd_en |=> $stable(reg_rdata))
    else $error("read data moved without read");
endmodule : pbc_port_asserts

bind pbc_port pbc_port_asserts i_pbc_port_asserts (
  .clock(clock), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup_en(pin_pullup_en),
  .pin_ttl_sel(pin_ttl_sel), .pin_analog_en(pin_analog_en), .periph_in(periph_in));

// ===== test/pbc_port_tb.sv
// self-checking bench for the eight-bit configurable port
`timescale 1ns/1ps
module pbc_port_tb;
  import pbc_pkg::*;
  logic         clock, resetn, instr_start, instr_end;
  pbc_reg_req_t reg_req;
  logic [7:0]   reg_rdata, pin_in, pin_out, pin_oe_n, pin_pullup_en, pin_ttl_sel;
  logic [7:0]   pin_analog_en, periph_in, ext_val, ext_en, d, p, u, e, got, exp_out;
  logic [15:0]  periph_out, periph_attached;
  int           mismatches, n_checks, cycles;

  pbc_port i_pbc_port (.clock(clock), .resetn(resetn), .instr_start(instr_start),
    .instr_end(instr_end), .reg_req(reg_req), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup_en(pin_pullup_en),
    .pin_ttl_sel(pin_ttl_sel), .pin_analog_en(pin_analog_en), .periph_out(periph_out),
    .periph_attached(periph_attached), .periph_in(periph_in));
  pbc_pins_model i_pbc_pins_model (.clock(clock), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup_en(pin_pullup_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  // ****************************************
  // helpers
  // ****************************************
  // and of attached sources, high when none
  function automatic logic [7:0] af_exp(input logic [15:0] o, input logic [15:0] a);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = &(o[2*i +: 2] | ~a[2*i +: 2]);
    return r;
  endfunction : af_exp
  task automatic chk(input logic [7:0] gv, input logic [7:0] ev);
    n_checks++;
    if (gv !== ev) begin
      $display("wrong value at %0t got %h exp %h", $time, gv, ev);
      mismatches++;
    end
  endtask : chk
  task automatic wr(input logic [1:0] sel, input logic [7:0] data);
    @(posedge clock);
    reg_req <= '{sel: sel, wr_en: 1'b1, rd_en: 1'b0, wdata: data};
    @(posedge clock);
    reg_req.wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] sel, output logic [7:0] data);
    @(posedge clock);
    reg_req <= '{sel: sel, wr_en: 1'b0, rd_en: 1'b1, wdata: 8'h00};
    @(posedge clock);
    reg_req.rd_en <= 1'b0;
    #1;
    data = reg_rdata;
  endtask : rd
  // lower cleared first so no stray peripheral mode appears on the way
  task automatic cfg(input logic [7:0] up, input logic [7:0] mid, input logic [7:0] lo);
    wr(PBC_SEL_LOWER, 8'h00);
    wr(PBC_SEL_MID, mid);
    wr(PBC_SEL_LOWER, lo);
    wr(PBC_SEL_UPPER, up);
  endtask : cfg
  task automatic pulse(input logic s, input logic t);
    @(posedge clock);
    instr_start <= s;
    instr_end   <= t;
    @(posedge clock);
    instr_start <= 1'b0;
    instr_end   <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask : pulse
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // ****************************************
  // clock, timeout and tests
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    {instr_start, instr_end, resetn} = 3'h0;
    reg_req = '0;
    {periph_out, periph_attached, ext_val, ext_en} = 48'h0;
    {mismatches, n_checks, cycles} = 96'h0;
    d = 8'($urandom(34));
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    #1;
    chk(pin_out, PBC_DATA_RST);
    chk(pin_pullup_en, PBC_WPU_PINS);
    rd(PBC_SEL_DATA, got);
    chk(got, 8'hff);
    rd(PBC_SEL_LOWER, got);
    chk(got, PBC_CTRL_RST);
    for (int k = 0; k < 4; k++) begin
      u = (k % 2 == 1) ? 8'hff : 8'h00;
      d = (k == 3) ? 8'h00 : 8'($urandom);
      cfg(u, 8'hff, 8'h00);
      wr(PBC_SEL_DATA, d);
      pulse(1'b0, 1'b1);
      chk(pin_out, d);
      chk(pin_oe_n, u & d);
      rd(PBC_SEL_DATA, got);
      chk(got, d);
      rd(PBC_SEL_UPPER, got);
      chk(got, u);
    end
    u = 8'($urandom);
    p = 8'($urandom);
    cfg(u, 8'h00, 8'hff);
    ext_en  <= 8'hff;
    ext_val <= p;
    wr(PBC_SEL_DATA, ~p);
    pulse(1'b1, 1'b1);
    chk(pin_oe_n, 8'hff);
    chk(pin_ttl_sel, u);
    chk(periph_in, p);
    rd(PBC_SEL_DATA, got);
    chk(got, p);
    ext_en <= 8'h00;
    cfg(8'h00, 8'hff, 8'h00);
    pulse(1'b0, 1'b0);
    chk(pin_out, ~p);
    u = 8'($urandom);
    d = 8'($urandom);
    e = 8'($urandom);
    cfg(u, 8'h00, 8'h00);
    wr(PBC_SEL_DATA, d);
    ext_en  <= e | u;
    ext_val <= 8'h00;
    pulse(1'b0, 1'b1);
    pulse(1'b1, 1'b0);
    chk(pin_pullup_en, ~u & PBC_WPU_PINS);
    chk(pin_oe_n, d);
    rd(PBC_SEL_DATA, got);
    chk(got, d & ~(e | u));
    d = d | 8'h80;
    wr(PBC_SEL_DATA, d);
    pulse(1'b0, 1'b1);
    chk(pin_oe_n, d);
    ext_en <= 8'h00;
    for (int k = 0; k < 2; k++) begin
      u = (k == 1) ? 8'hff : 8'h00;
      cfg(u, 8'hff, 8'hff);
      for (int j = 0; j < 3; j++) begin
        @(posedge clock);
        periph_out      <= 16'($urandom);
        periph_attached <= (j == 0) ? 16'h0000 : 16'($urandom);
        repeat (3) @(posedge clock);
        #1;
        exp_out = af_exp(periph_out, periph_attached) | (u & PBC_ADC_PINS);
        chk(pin_out, exp_out);
        chk(pin_oe_n, u & exp_out);
        chk(pin_analog_en, u & PBC_ADC_PINS);
        chk(pin_ttl_sel, ~PBC_SCHM_PINS);
      end
    end
    end_sim();
  end
endmodule : pbc_port_tb
